/* File: rtl/sad_pkg.sv */
/*
  Package for the system address decoder: region bounds, destinations,
  master identifiers and timing constants.
  Assumes 32-bit byte addresses on every master port.
*/
package sad_pkg;

  localparam int unsigned ADDR_W = 32;

  // Region bases and top addresses (inclusive).
  localparam logic [31:0] PFLASH_BASE = 32'h0000_0000;
  localparam logic [31:0] PFLASH_TOP  = 32'h07ff_ffff;
  localparam logic [31:0] VECT_TOP    = 32'h0000_03ff;
  localparam logic [31:0] ALIAS0_BASE = 32'h0800_0000;
  localparam logic [31:0] ALIAS0_TOP  = 32'h0fff_ffff;
  localparam logic [31:0] DFLASH_BASE = 32'h1000_0000;
  localparam logic [31:0] DFLASH_TOP  = 32'h13ff_ffff;
  localparam logic [31:0] FRAM_BASE   = 32'h1400_0000;
  localparam logic [31:0] FRAM_TOP    = 32'h17ff_ffff;
  localparam logic [31:0] ALIAS1_BASE = 32'h1800_0000;
  localparam logic [31:0] ALIAS1_TOP  = 32'h1bff_ffff;
  localparam logic [31:0] SRAML_BASE  = 32'h1c00_0000;
  localparam logic [31:0] SRAML_TOP   = 32'h1fff_ffff;
  localparam logic [31:0] SRAMU_BASE  = 32'h2000_0000;
  localparam logic [31:0] SRAMU_TOP   = 32'h200f_ffff;

  // Extra wait states the core sees on the external-bus alias.
  localparam int unsigned ALIAS_WAIT = 0;

  // Master number of the processor core.
  localparam logic [1:0] CORE_ID = 2'h0;

  typedef enum logic [2:0] {
    SAD_DST_PFLASH,
    SAD_DST_DFLASH,
    SAD_DST_FRAM,
    SAD_DST_EXTBUS,
    SAD_DST_SRAML,
    SAD_DST_SRAMU,
    SAD_DST_ERROR
  } sad_dst_e;

endpackage : sad_pkg

/* File: rtl/sad_region_dec.sv */
/*
  Combinational decode of one address and master number to a destination.
  Assumes the address is stable while valid is high.
*/
`timescale 1ns/1ps
module sad_region_dec
  import sad_pkg::*;
#(
  parameter bit HAS_DFLASH = 1'b1
) (
  // Request.
  input  wire logic [31:0]    addr,
  input  wire logic [1:0]     master,
  // Result.
  output sad_pkg::sad_dst_e   dst,
  output logic                vector_hit
);

  always_comb begin
    dst        = SAD_DST_ERROR;
    vector_hit = (addr <= VECT_TOP);
    if (addr <= PFLASH_TOP) begin
      dst = SAD_DST_PFLASH;
    end else if ((addr >= ALIAS0_BASE && addr <= ALIAS0_TOP) ||
                 (addr >= ALIAS1_BASE && addr <= ALIAS1_TOP)) begin
      dst = (master == CORE_ID) ? SAD_DST_EXTBUS : SAD_DST_ERROR;
    end else if (addr >= DFLASH_BASE && addr <= DFLASH_TOP) begin
      dst = HAS_DFLASH ? SAD_DST_DFLASH : SAD_DST_ERROR;
    end else if (addr >= FRAM_BASE && addr <= FRAM_TOP) begin
      dst = SAD_DST_FRAM;
    end else if (addr >= SRAML_BASE && addr <= SRAML_TOP) begin
      dst = SAD_DST_SRAML;
    end else if (addr >= SRAMU_BASE && addr <= SRAMU_TOP) begin
      dst = SAD_DST_SRAMU;
    end
  end

endmodule : sad_region_dec

/* File: rtl/sad_decoder.sv */
/*
  System address decoder: routes each master request to one destination
  select and terminates illegal accesses with a bus error.
  Assumes a request is held until rsp_valid, and slaves answer ready.
*/
// Operation
// - Low 128 MB goes to program flash.
// - First 1024 bytes are flash vectors.
// - Alias windows to external bus, core only.
// - Fourth region to flash RAM, all masters.
// - Lower SRAM region to lower bank.
// - First megabyte of system SRAM upper bank.
`timescale 1ns/1ps
module sad_decoder
  import sad_pkg::*;
#(
  parameter bit HAS_DFLASH = 1'b1
) (
  // Clock and reset.
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Master request.
  input  wire logic         req_valid,
  input  wire logic [31:0]  req_addr,
  input  wire logic [1:0]   req_master,
  // Slave handshake.
  input  wire logic         slv_ready,
  // Slave select, one level per destination, plus sel_vector for vector hits in program flash.
  output logic              sel_pflash,
  output logic              sel_dflash,
  output logic              sel_fram,
  output logic              sel_extbus,
  output logic              sel_sraml,
  output logic              sel_sramu,
  output logic              sel_vector,
  // Response to the master.
  output logic              rsp_valid,
  output logic              rsp_error
);

  typedef enum logic [1:0] {
    SAD_IDLE,
    SAD_ERR,
    SAD_DONE
  } sad_state_e;

  typedef struct packed {
    sad_state_e state;
    logic       err;
  } sad_state_s;

  sad_state_s state_reg;
  sad_state_s state_next;
  sad_dst_e   dst;
  logic       vec_hit;
  logic       legal;

  sad_region_dec #(
    .HAS_DFLASH (HAS_DFLASH)
  ) u_dec (
    .addr       (req_addr),
    .master     (req_master),
    .dst        (dst),
    .vector_hit (vec_hit)
  );

  assign legal      = req_valid && (dst != SAD_DST_ERROR) &&
                      (state_reg.state == SAD_IDLE);
  assign sel_pflash = legal && (dst == SAD_DST_PFLASH);
  assign sel_vector = legal && (dst == SAD_DST_PFLASH) && vec_hit;
  assign sel_dflash = legal && (dst == SAD_DST_DFLASH);
  assign sel_fram   = legal && (dst == SAD_DST_FRAM);
  assign sel_extbus = legal && (dst == SAD_DST_EXTBUS);
  assign sel_sraml  = legal && (dst == SAD_DST_SRAML);
  assign sel_sramu  = legal && (dst == SAD_DST_SRAMU);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg.state)
      SAD_IDLE: begin
        state_next.err = 1'b0;
        if (req_valid && dst == SAD_DST_ERROR) begin
          state_next.state = SAD_ERR;
          state_next.err   = 1'b1;
        end else if (legal && slv_ready) begin
          state_next.state = SAD_DONE;
        end
      end
      SAD_ERR: begin
        state_next.state = SAD_IDLE;
        state_next.err   = 1'b0;
      end
      SAD_DONE: begin
        state_next.state = SAD_IDLE;
      end
      // The unused fourth state code falls back to idle.
      default: begin
        state_next = '{state: SAD_IDLE, err: 1'b0};
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{state: SAD_IDLE, err: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign rsp_valid = (state_reg.state != SAD_IDLE);
  assign rsp_error = state_reg.err;

endmodule : sad_decoder

/* File: verification/sad_asserts.sv */
/*
  Port checker for the system address decoder.
  Assumes requests are held until rsp_valid, as the bench does.
*/
`timescale 1ns/1ps
module sad_asserts (
  input wire logic        clk_sys, rst_n, req_valid, slv_ready,
  input wire logic [31:0] req_addr,
  input wire logic [1:0]  req_master,
  input wire logic        sel_pflash, sel_dflash, sel_fram, sel_extbus,
  input wire logic        sel_sraml, sel_sramu, sel_vector,
  input wire logic        rsp_valid, rsp_error
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire logic idle  = req_valid && !rsp_valid;
  wire logic in_alias =
    (req_addr >= 32'h0800_0000 && req_addr <= 32'h0fff_ffff) ||
    (req_addr >= 32'h1800_0000 && req_addr <= 32'h1bff_ffff);
  a_flash_route: assert property (
    idle && req_addr <= 32'h07ff_ffff |-> sel_pflash && !sel_extbus)
    else $error("flash select missing");
  a_vector_hit: assert property (
    idle && req_addr <= 32'h0000_03ff |-> sel_vector && sel_pflash)
    else $error("vector select missing");
  a_alias_core: assert property (
    idle && in_alias |-> sel_extbus == (req_master == 2'h0))
    else $error("alias select wrong");
  a_alias_nowait: assert property (
    sel_extbus && slv_ready |=> rsp_valid && !rsp_error)
    else $error("alias access delayed");
  a_fram_route: assert property (
    idle && req_addr[31:26] == 6'h05 |-> sel_fram)
    else $error("flash ram select missing");
  a_sraml_route: assert property (
    idle && req_addr[31:26] == 6'h07 |-> sel_sraml)
    else $error("lower sram select missing");
  a_sramu_route: assert property (
    idle && req_addr[31:20] == 12'h200 |-> sel_sramu)
    else $error("upper sram select missing");
  a_error_resp: assert property (
    idle && (req_addr >= 32'h2010_0000 || in_alias && req_master != 2'h0)
    |-> {sel_pflash, sel_dflash, sel_fram, sel_extbus, sel_sraml,
    sel_sramu} == 6'h0 ##1 rsp_valid && rsp_error)
    else $error("illegal access not refused");
  c_alias: cover property (sel_extbus && slv_ready);
  c_error: cover property (rsp_valid && rsp_error);
  c_vector: cover property (sel_vector && slv_ready);
endmodule : sad_asserts

bind sad_decoder sad_asserts u_chk (.*);

/* File: verification/sad_slave_model.sv */
/*
  Behavioural slave side: answers ready after random stalls.
  Assumes the system clock and active-low reset.
*/
`timescale 1ns/1ps
module sad_slave_model (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  output logic      slv_ready
);
  int seed = 32'h0bad_5eed;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) slv_ready <= 1'b0;
    else slv_ready <= ($random(seed) % 3) != 0;
  end
endmodule : sad_slave_model

/* File: verification/test_system_address_decoder.sv */
/*
  Self-checking bench for the system address decoder.
  Assumes the slave model and the bound port checker.
*/
`timescale 1ns/1ps
module test_system_address_decoder;
  logic clk_sys = 0, rst_n = 0, req_valid = 0, slv_ready;
  logic [31:0] req_addr = 0;
  logic [1:0]  req_master = 0;
  logic [5:0]  sel;
  logic        sel_vector, rsp_valid, rsp_error;
  int num_errors = 0, cmp_count = 0, cyc = 0, seed = 32'h36edd58a, d, n;
  logic [31:0] tbl [18] = '{32'h0, 32'h3ff, 32'h400, 32'h07ff_ffff,
    32'h0800_0000, 32'h0fff_ffff, 32'h1000_0000, 32'h13ff_ffff,
    32'h1400_0000, 32'h17ff_ffff, 32'h1800_0000, 32'h1bff_ffff,
    32'h1c00_0000, 32'h1fff_ffff, 32'h2000_0000, 32'h200f_ffff,
    32'h2010_0000, 32'hffff_ffff};
  always #5 clk_sys = ~clk_sys;
  sad_decoder DUT (.clk_sys, .rst_n, .req_valid, .req_addr, .req_master,
    .slv_ready, .sel_pflash(sel[0]), .sel_dflash(sel[1]),
    .sel_fram(sel[2]), .sel_extbus(sel[3]), .sel_sraml(sel[4]),
    .sel_sramu(sel[5]), .sel_vector, .rsp_valid, .rsp_error);
  sad_slave_model u_slv (.clk_sys, .rst_n, .slv_ready);
  function automatic int exp_dst(logic [31:0] a, logic [1:0] m);
    if (a <= 32'h07ff_ffff) return 0;
    if (a <= 32'h0fff_ffff || (a >= 32'h1800_0000 && a <= 32'h1bff_ffff))
      return m == 2'h0 ? 3 : 6;
    if (a <= 32'h13ff_ffff) return 1;
    if (a <= 32'h17ff_ffff) return 2;
    if (a <= 32'h1fff_ffff) return 4;
    if (a <= 32'h200f_ffff) return 5;
    return 6;
  endfunction : exp_dst
  task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 80; i++) begin
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_addr <= i < 36 ? tbl[i % 18] : $random(seed);
      req_master <= i < 18 ? 2'h0
        : i < 36 ? 2'(1 + i % 3) : 2'($random(seed));
      @(negedge clk_sys);
      d = exp_dst(req_addr, req_master);
      chk("select", d < 6 ? 8'(1 << d) : 8'h0, {2'b0, sel});
      chk("vector", 8'(req_addr <= 32'h3ff), {7'b0, sel_vector});
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20) begin
        @(negedge clk_sys);
        n++;
      end
      chk("response", {6'b0, 1'b1, d == 6}, {6'b0, rsp_valid, rsp_error});
      chk("response select", 8'h0, {2'b0, sel});
    end
    $display("decode sweep done");
    @(posedge clk_sys);
    req_valid <= 1'b0;
    @(negedge clk_sys);
    chk("idle select", 8'h0, {2'b0, sel});
    $display("idle test done");
    final_report();
  end
endmodule : test_system_address_decoder
